// [logic/uart_status_control.sv]
// serial port status and control: transmitter, receiver, status register
// assumes a plain register port; the pin mux outside takes tx_drive high to mean port owns pin
`timescale 1ns/1ps
`default_nettype none
`include "uart_sc_params.svh"
module uart_status_control (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        serial_rx_pin,
    output logic             serial_tx_pin,
    output logic             tx_drive,
    output logic             tx_irq,
    output logic             rx_irq
);
    // ---------------- registers ----------------
    logic [1:0]  tx_irq_mode_q;
    logic        tx_polarity_invert_q;
    logic        send_break_request_q;
    logic        tx_enable_bit_q;
    logic [1:0]  rx_irq_mode_q;
    logic        address_detect_enable_q;
    logic        rx_overrun_flag_q;
    logic        parity_error_flag_q;
    logic        framing_error_flag_q;
    logic        infrared_encode_enable_q;
    logic [15:0] divisor_q;
    logic [15:0] reg_rdata_q;

    wire wr_status = reg_wr && (reg_addr == `SC_OFF_STATUS);
    wire wr_txdata = reg_wr && (reg_addr == `SC_OFF_TXDATA);
    wire wr_div    = reg_wr && (reg_addr == `SC_OFF_DIVISOR);
    wire wr_mode   = reg_wr && (reg_addr == `SC_OFF_MODE);
    wire rd_rxdata = reg_rd && (reg_addr == `SC_OFF_RXDATA);

    // ---------------- transmit path ----------------
    uart_sc_pkg::tx_state_e tx_state_q;
    logic [3:0]  tx_bits_q;
    logic [7:0]  tx_shift_q;
    logic        tx_is_break_q;
    logic        tx_line_q;
    logic [2:0]  tx_count;
    logic [8:0]  tx_head;
    logic        tx_tick;
    wire         tx_flush = !tx_enable_bit_q;
    wire         tx_busy  = (tx_state_q != uart_sc_pkg::TX_IDLE);
    wire         tx_load  = tx_enable_bit_q && !tx_busy && (tx_count != 3'h0);
    wire         tx_fin   = tx_tick && (tx_state_q == uart_sc_pkg::TX_STOP);
    wire         tx_full  = (tx_count == 3'(`SC_TXFIFO_DEPTH));
    wire         tx_empty_all = !tx_busy && (tx_count == 3'h0);

    sc_char_fifo #(.DEPTH(`SC_TXFIFO_DEPTH), .WIDTH(9)) tx_fifo (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .flush     (tx_flush),
        .push      (wr_txdata && tx_enable_bit_q),
        .push_data ({send_break_request_q, reg_wdata[7:0]}),
        .pop       (tx_load),
        .head_data (tx_head),
        .count     (tx_count)
    );

    sc_bit_timer tx_timer (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .run     (tx_busy),
        .divisor (divisor_q),
        .preload (divisor_q),
        .tick    (tx_tick)
    );

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_state_q    <= uart_sc_pkg::TX_IDLE;
            tx_bits_q     <= 4'h0;
            tx_shift_q    <= 8'h00;
            tx_is_break_q <= 1'b0;
            tx_line_q     <= 1'b1;
        end else if (tx_flush) begin
            tx_state_q <= uart_sc_pkg::TX_IDLE;
            tx_line_q  <= 1'b1;
        end else begin
            case (tx_state_q)
                uart_sc_pkg::TX_IDLE: begin
                    tx_line_q <= 1'b1;
                    if (tx_load) begin
                        tx_state_q    <= uart_sc_pkg::TX_START;
                        tx_shift_q    <= tx_head[8] ? 8'h00 : tx_head[7:0];
                        tx_is_break_q <= tx_head[8];
                        tx_line_q     <= 1'b0;
                    end
                end
                uart_sc_pkg::TX_START: begin
                    if (tx_tick) begin
                        tx_state_q <= uart_sc_pkg::TX_DATA;
                        tx_bits_q  <= tx_is_break_q ? `SC_BREAK_ZEROS : `SC_DATA_BITS;
                        tx_line_q  <= tx_is_break_q ? 1'b0 : tx_shift_q[0];
                    end
                end
                uart_sc_pkg::TX_DATA: begin
                    if (tx_tick) begin
                        tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                        tx_bits_q  <= tx_bits_q - 4'h1;
                        tx_line_q  <= (tx_bits_q == 4'h1) ? 1'b1 : tx_shift_q[1];
                        if (tx_bits_q == 4'h1) begin
                            tx_state_q <= uart_sc_pkg::TX_STOP;
                        end
                    end
                end
                uart_sc_pkg::TX_STOP: begin
                    if (tx_tick) begin
                        tx_state_q <= uart_sc_pkg::TX_IDLE;
                    end
                end
                default: tx_state_q <= uart_sc_pkg::TX_IDLE;
            endcase
        end
    end

    // infrared coding: short high pulse in the first part of each zero bit
    logic [15:0] ir_cnt_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ir_cnt_q <= 16'h0000;
        end else begin
            ir_cnt_q <= tx_tick || !tx_busy ? 16'h0000 : ir_cnt_q + 16'h0001;
        end
    end
    wire ir_pulse = tx_busy && !tx_line_q
                    && (ir_cnt_q < (divisor_q >> `SC_IR_PULSE_DIV));
    wire pin_plain = tx_line_q ^ tx_polarity_invert_q;
    wire pin_ir    = ir_pulse ^ tx_polarity_invert_q;
    wire pin_next  = infrared_encode_enable_q ? pin_ir : pin_plain;

    // ---------------- receive path ----------------
    uart_sc_pkg::rx_state_e rx_state_q;
    logic [3:0]  rx_bits_q;
    logic [7:0]  rx_shift_q;
    logic [2:0]  rx_count;
    logic [8:0]  rx_head;
    logic        rx_tick;
    logic        rx_push_q;
    wire         rx_busy  = (rx_state_q != uart_sc_pkg::RX_IDLE);
    wire         rx_done  = rx_tick && (rx_state_q == uart_sc_pkg::RX_STOP);
    wire         rx_full  = (rx_count == 3'(`SC_RXFIFO_DEPTH));
    wire         rx_store = rx_done && !rx_full && !rx_overrun_flag_q;

    sc_char_fifo #(.DEPTH(`SC_RXFIFO_DEPTH), .WIDTH(9)) rx_fifo (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .flush     (1'b0),
        .push      (rx_store),
        .push_data ({!serial_rx_pin, rx_shift_q}),
        .pop       (rd_rxdata),
        .head_data (rx_head),
        .count     (rx_count)
    );

    sc_bit_timer rx_timer (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .run     (rx_busy),
        .divisor (divisor_q),
        .preload ({1'b0, divisor_q[15:1]}),
        .tick    (rx_tick)
    );

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_state_q <= uart_sc_pkg::RX_IDLE;
            rx_bits_q  <= 4'h0;
            rx_shift_q <= 8'h00;
        end else begin
            case (rx_state_q)
                uart_sc_pkg::RX_IDLE: begin
                    if (!serial_rx_pin) begin
                        rx_state_q <= uart_sc_pkg::RX_START;
                    end
                end
                uart_sc_pkg::RX_START: begin
                    if (rx_tick) begin
                        rx_state_q <= serial_rx_pin ? uart_sc_pkg::RX_IDLE : uart_sc_pkg::RX_DATA;
                        rx_bits_q  <= `SC_DATA_BITS;
                    end
                end
                uart_sc_pkg::RX_DATA: begin
                    if (rx_tick) begin
                        rx_shift_q <= {serial_rx_pin, rx_shift_q[7:1]};
                        rx_bits_q  <= rx_bits_q - 4'h1;
                        if (rx_bits_q == 4'h1) begin
                            rx_state_q <= uart_sc_pkg::RX_STOP;
                        end
                    end
                end
                uart_sc_pkg::RX_STOP: begin
                    if (rx_tick) begin
                        rx_state_q <= uart_sc_pkg::RX_IDLE;
                    end
                end
                default: rx_state_q <= uart_sc_pkg::RX_IDLE;
            endcase
        end
    end

    // ---------------- interrupts ----------------
    wire tx_i_each  = tx_load;
    wire tx_i_empty = tx_load && (tx_count == 3'h1);
    wire tx_i_done  = tx_fin && (tx_count == 3'h0);
    wire rx_i_each  = rx_store;
    wire rx_i_34    = rx_store && (rx_count == 3'h2);
    wire rx_i_full  = rx_store && (rx_count == (`SC_RX_THRESH - 3'h1));
    wire tx_irq_d   = (tx_irq_mode_q == uart_sc_pkg::TXI_EACH_MOVE) ? tx_i_each :
                      (tx_irq_mode_q == uart_sc_pkg::TXI_BUF_EMPTY) ? tx_i_empty :
                      (tx_irq_mode_q == uart_sc_pkg::TXI_ALL_DONE)  ? tx_i_done : 1'b0;
    wire rx_irq_d   = (rx_irq_mode_q == uart_sc_pkg::RXI_FULL)          ? rx_i_full :
                      (rx_irq_mode_q == uart_sc_pkg::RXI_THREE_QUARTER) ? rx_i_34 : rx_i_each;

    // ---------------- register writes ----------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_irq_mode_q            <= 2'h0;
            tx_polarity_invert_q     <= 1'b0;
            send_break_request_q     <= 1'b0;
            tx_enable_bit_q          <= 1'b0;
            rx_irq_mode_q            <= 2'h0;
            address_detect_enable_q  <= 1'b0;
            rx_overrun_flag_q        <= 1'b0;
            parity_error_flag_q      <= 1'b0;
            framing_error_flag_q     <= 1'b0;
            infrared_encode_enable_q <= 1'b0;
            divisor_q                <= `SC_DIV_RESET;
        end else begin
            if (wr_status) begin
                tx_irq_mode_q           <= {reg_wdata[`SC_BIT_TXISEL1], reg_wdata[`SC_BIT_TXISEL0]};
                tx_polarity_invert_q    <= reg_wdata[`SC_BIT_TXINV];
                tx_enable_bit_q         <= reg_wdata[`SC_BIT_TXEN];
                rx_irq_mode_q           <= reg_wdata[`SC_BIT_RXISEL1:`SC_BIT_RXISEL0];
                address_detect_enable_q <= reg_wdata[`SC_BIT_ADDRESS_DETECT_ENABLE];
            end
            // break request: set by software, cleared when its frame ends or when transmit is disabled; set wins
            if (wr_status && reg_wdata[`SC_BIT_TXBRK]) begin
                send_break_request_q <= 1'b1;
            end else if ((tx_fin && tx_is_break_q) || tx_flush) begin
                send_break_request_q <= 1'b0;
            end
            // overrun: set on a lost character, cleared only by writing zero; set wins
            if (rx_done && rx_full) begin
                rx_overrun_flag_q <= 1'b1;
            end else if (wr_status && !reg_wdata[`SC_BIT_RX_OVERRUN_FLAG]) begin
                rx_overrun_flag_q <= 1'b0;
            end
            if (rx_done) begin
                framing_error_flag_q <= !serial_rx_pin;
                parity_error_flag_q  <= 1'b0;
            end
            if (wr_mode) begin
                infrared_encode_enable_q <= reg_wdata[`SC_BIT_INFRARED_ENCODE_ENABLE];
            end
            if (wr_div) begin
                divisor_q <= reg_wdata;
            end
        end
    end

    // ---------------- readback ----------------
    wire [15:0] status_word = {tx_irq_mode_q[1], tx_polarity_invert_q, tx_irq_mode_q[0], 1'b0,
                               send_break_request_q, tx_enable_bit_q, tx_full, tx_empty_all,
                               rx_irq_mode_q, address_detect_enable_q, !rx_busy,
                               parity_error_flag_q, framing_error_flag_q, rx_overrun_flag_q,
                               (rx_count != 3'h0)};
    wire [15:0] rd_mux = (reg_addr == `SC_OFF_STATUS)  ? status_word :
                         (reg_addr == `SC_OFF_RXDATA)  ? {8'h00, rx_head[7:0]} :
                         (reg_addr == `SC_OFF_DIVISOR) ? divisor_q :
                         (reg_addr == `SC_OFF_MODE)    ? {15'h0000, infrared_encode_enable_q} :
                         16'h0000;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_q   <= 16'h0000;
            serial_tx_pin <= 1'b1;
            tx_drive      <= 1'b0;
            tx_irq        <= 1'b0;
            rx_irq        <= 1'b0;
            rx_push_q     <= 1'b0;
        end else begin
            reg_rdata_q   <= reg_rd ? rd_mux : 16'h0000;
            serial_tx_pin <= pin_next;
            tx_drive      <= tx_enable_bit_q;
            tx_irq        <= tx_irq_d;
            rx_irq        <= rx_irq_d;
            rx_push_q     <= rx_store;
        end
    end
    assign reg_rdata = reg_rdata_q;

    // ---------------- checks ----------------
    shift_empty_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (wr_txdata && tx_enable_bit_q && !tx_full) |=> !status_word[`SC_BIT_TX_SHIFT_EMPTY_FLAG])
        else $error("shift empty flag set with a character queued");
    full_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (wr_txdata && tx_enable_bit_q && !tx_load && !status_word[`SC_BIT_TXBF])
            |=> tx_count == $past(tx_count) + 3'h1)
        else $error("character refused while buffer not full");
    tx_abort_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(tx_enable_bit_q) |=> (tx_count == 3'h0 && !tx_busy && !tx_drive))
        else $error("transmit disable did not abort");
    tx_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        tx_enable_bit_q |=> tx_drive)
        else $error("pin not driven while enabled");
    idle_level_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!infrared_encode_enable_q && !tx_busy) |=> serial_tx_pin == !$past(tx_polarity_invert_q))
        else $error("plain idle level wrong");
    ir_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (infrared_encode_enable_q && !tx_busy) |=> serial_tx_pin == $past(tx_polarity_invert_q))
        else $error("infrared idle level wrong");
    break_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (tx_fin && tx_is_break_q && !wr_status) |=> !send_break_request_q)
        else $error("break request not cleared");
    break_len_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (tx_state_q == uart_sc_pkg::TX_START && tx_tick && tx_is_break_q) |=> tx_bits_q == 4'hC)
        else $error("break length wrong");
    rx_full_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (rx_irq_mode_q == uart_sc_pkg::RXI_FULL && rx_irq) |-> $past(rx_store) && rx_count == 3'h4)
        else $error("full receive interrupt at wrong fill");
    rx_each_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (rx_irq_mode_q == uart_sc_pkg::RXI_EACH_CHAR && rx_store) |=> rx_irq && rx_push_q)
        else $error("missing per-character interrupt");
    tx_irq_each_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (tx_irq_mode_q == uart_sc_pkg::TXI_EACH_MOVE && tx_load) |=> tx_irq)
        else $error("missing transmit move interrupt");
endmodule : uart_status_control
`default_nettype wire

// [logic/uart_sc_params.svh]
// constants for the serial status and control block: offsets, fields, resets, timing
// assumes nothing; included by the top design file and the bench
`ifndef UART_SC_PARAMS_SVH
`define UART_SC_PARAMS_SVH

`define SC_ADDR_W          4
`define SC_OFF_STATUS      4'h0
`define SC_OFF_TXDATA      4'h1
`define SC_OFF_RXDATA      4'h2
`define SC_OFF_DIVISOR     4'h3
`define SC_OFF_MODE        4'h4

`define SC_BIT_TXISEL1     15
`define SC_BIT_TXINV       14
`define SC_BIT_TXISEL0     13
`define SC_BIT_TXBRK       11
`define SC_BIT_TXEN        10
`define SC_BIT_TXBF        9
`define SC_BIT_TX_SHIFT_EMPTY_FLAG        8
`define SC_BIT_RXISEL1     7
`define SC_BIT_RXISEL0     6
`define SC_BIT_ADDRESS_DETECT_ENABLE       5
`define SC_BIT_RECEIVER_IDLE_FLAG       4
`define SC_BIT_PARITY_ERROR_FLAG        3
`define SC_BIT_FRAMING_ERROR_FLAG        2
`define SC_BIT_RX_OVERRUN_FLAG        1
`define SC_BIT_RXDA        0
`define SC_BIT_INFRARED_ENCODE_ENABLE        0

`define SC_STATUS_RESET    16'h0110
`define SC_DIV_RESET       16'h006B
`define SC_TXFIFO_DEPTH    4
`define SC_RXFIFO_DEPTH    4
`define SC_RX_THRESH       3'h4
`define SC_BREAK_ZEROS     4'hC
`define SC_DATA_BITS       4'h8
`define SC_IR_PULSE_DIV    2

`endif

// [logic/uart_sc_pkg.sv]
// types of the serial status and control block
// assumes the params header is on the include path
package uart_sc_pkg;
    typedef enum logic [1:0] {
        TXI_EACH_MOVE,
        TXI_ALL_DONE,
        TXI_BUF_EMPTY,
        TXI_RESERVED
    } tx_irq_mode_e;

    typedef enum logic [1:0] {
        RXI_EACH_CHAR,
        RXI_EACH_CHAR_ALT,
        RXI_THREE_QUARTER,
        RXI_FULL
    } rx_irq_mode_e;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_STOP
    } tx_state_e;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } rx_state_e;
endpackage : uart_sc_pkg

// [logic/sc_char_fifo.sv]
// small character fifo with flush, used for transmit and receive buffering
// assumes one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module sc_char_fifo #(
    parameter int DEPTH = 4,
    parameter int WIDTH = 9
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             flush,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] head_data,
    output logic      [2:0]       count
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [1:0]       wr_q;
    logic [1:0]       rd_q;
    logic [2:0]       cnt_q;
    wire              do_push = push && (cnt_q != 3'(DEPTH));
    wire              do_pop  = pop && (cnt_q != 3'h0);

    assign head_data = mem_q[rd_q];
    assign count     = cnt_q;

    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem_q[wr_q] <= push_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q  <= 2'h0;
            rd_q  <= 2'h0;
            cnt_q <= 3'h0;
        end else if (flush) begin
            wr_q  <= 2'h0;
            rd_q  <= 2'h0;
            cnt_q <= 3'h0;
        end else begin
            wr_q  <= do_push ? wr_q + 2'h1 : wr_q;
            rd_q  <= do_pop ? rd_q + 2'h1 : rd_q;
            cnt_q <= cnt_q + 3'(do_push) - 3'(do_pop);
        end
    end
endmodule : sc_char_fifo
`default_nettype wire

// [logic/sc_bit_timer.sv]
// baud tick generator: one-cycle tick every divisor+1 cycles while running
// assumes divisor is stable during a frame
`timescale 1ns/1ps
`default_nettype none
module sc_bit_timer (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        run,
    input  wire logic [15:0] divisor,
    input  wire logic [15:0] preload,
    output logic             tick
);
    logic [15:0] cnt_q;

    assign tick = run && (cnt_q == 16'h0000);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 16'h0000;
        end else if (!run) begin
            cnt_q <= preload;
        end else begin
            cnt_q <= (cnt_q == 16'h0000) ? divisor : cnt_q - 16'h0001;
        end
    end
endmodule : sc_bit_timer
`default_nettype wire

// [dv/serial_node_model.sv]
// line-side model: decodes frames seen on the transmit pin, sends frames on the receive pin
// assumes 8N1, LSB first, a bit period of BIT_CYC clock cycles, normal polarity
`timescale 1ns/1ps
`default_nettype none
module serial_node_model #(
    parameter int BIT_CYC = 4
) (
    input  wire logic ref_clk,
    input  wire logic serial_tx_pin,
    output logic      serial_rx_pin
);
    logic [7:0] got_q[$];
    logic [7:0] b;
    int         low_cyc;
    initial serial_rx_pin = 1'b1;
    // sample each data bit near its middle, away from the launching edge
    always begin
        @(negedge serial_tx_pin);
        repeat (BIT_CYC / 2) @(negedge ref_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CYC) @(negedge ref_clk);
            if (i < 8) b[i] = serial_tx_pin;
        end
        got_q.push_back(b);
    end
    // length of the low run that opens each frame, bounded for an idle-low line
    always begin
        @(negedge serial_tx_pin);
        low_cyc = 0;
        @(negedge ref_clk);
        while (serial_tx_pin === 1'b0 && low_cyc < 200) begin
            low_cyc++;
            @(negedge ref_clk);
        end
    end
    task automatic send_byte(input logic [7:0] v);
        logic [9:0] f;
        f = {1'b1, v, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            serial_rx_pin <= f[i];
            repeat (BIT_CYC - 1) @(posedge ref_clk);
        end
    endtask : send_byte
endmodule : serial_node_model
`default_nettype wire

// [dv/test_uart_status_control.sv]
// self-checking bench: register tasks, line model, interrupt pulse counters
// assumes the design sources and the params header are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "uart_sc_params.svh"
module test_uart_status_control;
    localparam int BIT = 4;
    logic        ref_clk, rst_b, reg_wr, reg_rd;
    logic        serial_rx_pin, serial_tx_pin, tx_drive, tx_irq, rx_irq;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    int          errors, n_checks, t0;
    int          n_tx = 0;
    int          n_rx = 0;
    logic [15:0] mw[4] = '{16'h0400, 16'h2400, 16'h8400, 16'hA400};
    int          nc[4] = '{3, 3, 1, 1};
    int          ni[4] = '{3, 1, 1, 0};
    uart_status_control dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin), .tx_drive(tx_drive),
        .tx_irq(tx_irq), .rx_irq(rx_irq));
    serial_node_model #(.BIT_CYC(BIT)) node_u (.ref_clk(ref_clk),
        .serial_tx_pin(serial_tx_pin), .serial_rx_pin(serial_rx_pin));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (tx_irq === 1'b1) n_tx <= n_tx + 1;
        if (rx_irq === 1'b1) n_rx <= n_rx + 1;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic rdchk(input string nm, input logic [3:0] a, input logic [15:0] m,
                         input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        chk(nm, e, d & m);
    endtask : rdchk
    task automatic idle_wait();
        logic [15:0] d;
        d = 16'h0000;
        for (int i = 0; i < 300 && d[8] !== 1'b1; i++) rd(`SC_OFF_STATUS, d);
        chk("shift empty wait", 16'h0100, d & 16'h0100);
        repeat (4) @(posedge ref_clk);
    endtask : idle_wait
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        complete_run();
    end
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, errors, n_checks} = '0;
        rst_b = 1'b0;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        rdchk("status reset", `SC_OFF_STATUS, 16'hFFFF, 16'h0110);
        wr(4'hF, 16'hFFFF);
        rdchk("unmapped", 4'hF, 16'hFFFF, 16'h0000);
        wr(`SC_OFF_DIVISOR, 16'(BIT - 1));
        for (int k = 0; k < 4; k++) begin
            wr(`SC_OFF_STATUS, mw[k]);
            repeat (2) @(posedge ref_clk);
            chk("tx drive", 16'h0001, {15'h0, tx_drive});
            node_u.got_q.delete();
            t0 = n_tx;
            for (int j = 0; j < nc[k]; j++) wr(`SC_OFF_TXDATA, 16'h00A0 + 16'(j));
            idle_wait();
            chk("tx irq count", 16'(ni[k]), 16'(n_tx - t0));
            chk("tx last char", 16'h00A0 + 16'(nc[k] - 1), {8'h0, node_u.got_q[nc[k] - 1]});
        end
        $display("test tx modes done");
        node_u.got_q.delete();
        wr(`SC_OFF_STATUS, 16'h0400);
        for (int j = 0; j < 6; j++) wr(`SC_OFF_TXDATA, 16'h0030 + 16'(j));
        rdchk("full", `SC_OFF_STATUS, 16'h0300, 16'h0200);
        idle_wait();
        rdchk("not full", `SC_OFF_STATUS, 16'h0300, 16'h0100);
        chk("chars sent", 16'd5, 16'(node_u.got_q.size()));
        for (int j = 0; j < 3; j++) wr(`SC_OFF_TXDATA, 16'h0040);
        repeat (10) @(posedge ref_clk);
        wr(`SC_OFF_STATUS, 16'h0000);
        rdchk("abort", `SC_OFF_STATUS, 16'h0700, 16'h0100);
        chk("tx drive off", 16'h0000, {15'h0, tx_drive});
        repeat (60) @(posedge ref_clk);
        node_u.got_q.delete();
        wr(`SC_OFF_STATUS, 16'h0400);
        repeat (60) @(posedge ref_clk);
        chk("flushed", 16'd0, 16'(node_u.got_q.size()));
        $display("test buffer and abort done");
        for (int p = 0; p < 4; p++) begin
            wr(`SC_OFF_MODE, 16'(p[1]));
            wr(`SC_OFF_STATUS, 16'h0400 | (16'(p[0]) << 14));
            repeat (4) @(posedge ref_clk);
            chk("idle level", 16'(p[1] ? p[0] : !p[0]), {15'h0, serial_tx_pin});
        end
        wr(`SC_OFF_MODE, 16'h0000);
        wr(`SC_OFF_STATUS, 16'h0400);
        repeat (250) @(posedge ref_clk);
        wr(`SC_OFF_STATUS, 16'h0C00);
        rdchk("break set", `SC_OFF_STATUS, 16'h0800, 16'h0800);
        wr(`SC_OFF_TXDATA, 16'h00FF);
        idle_wait();
        chk("break low", 16'(13 * BIT), 16'(node_u.low_cyc));
        rdchk("break clear", `SC_OFF_STATUS, 16'h0800, 16'h0000);
        $display("test line levels done");
        wr(`SC_OFF_STATUS, 16'h0000);
        t0 = n_rx;
        node_u.send_byte(8'h3C);
        repeat (2 * BIT) @(posedge ref_clk);
        chk("rx irq each", 16'd1, 16'(n_rx - t0));
        rdchk("rx avail", `SC_OFF_STATUS, 16'h0001, 16'h0001);
        rdchk("rx data", `SC_OFF_RXDATA, 16'h00FF, 16'h003C);
        wr(`SC_OFF_STATUS, 16'h00C0);
        t0 = n_rx;
        for (int j = 0; j < 5; j++) begin
            node_u.send_byte(8'h50 + 8'(j));
            repeat (2 * BIT) @(posedge ref_clk);
            chk("rx irq four", 16'(j >= 3), 16'(n_rx - t0));
        end
        rdchk("overrun", `SC_OFF_STATUS, 16'h0002, 16'h0002);
        wr(`SC_OFF_STATUS, 16'h00C4);
        rdchk("flags", `SC_OFF_STATUS, 16'h0017, 16'h0011);
        for (int j = 0; j < 4; j++) begin
            rdchk("rx drain", `SC_OFF_RXDATA, 16'h00FF, 16'h0050 + 16'(j));
        end
        wr(`SC_OFF_STATUS, 16'h0080);
        t0 = n_rx;
        for (int j = 0; j < 3; j++) begin
            node_u.send_byte(8'h60 + 8'(j));
            repeat (2 * BIT) @(posedge ref_clk);
            chk("rx irq three", 16'(j >= 2), 16'(n_rx - t0));
        end
        $display("test receive done");
        complete_run();
    end
endmodule : test_uart_status_control
`default_nettype wire
